// ### rtl/dbc_cfg.svh
// Register offsets, field positions and fixed patterns of the overhead block
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH
`define DBC_ADDR_TX_CTRL 8'h41
`define DBC_ADDR_RX_CODE 8'h42
`define DBC_ADDR_TX_CODE 8'h43
`define DBC_ADDR_ALIGN 8'h50
`define DBC_ADDR_NONALIGN 8'h51
`define DBC_ADDR_SI_EVEN 8'h52
`define DBC_ADDR_SI_ODD 8'h53
`define DBC_ADDR_RAI 8'h54
`define DBC_RST_BYTE 8'h00
`define DBC_RST_CODE 6'h00
`define DBC_SEND_BIT 6
`define DBC_IDLE_FLAG 8'h7e
`define DBC_CODE_LEAD 8'hff
`define DBC_CODE_LEN 4'hf
`define DBC_IDLE_LEN 4'h7
`define DBC_RAI_POS 5
`define DBC_LAST_BIT 3'h7
`define DBC_FIRST_DATA 4'h1
`endif

// ### rtl/dbc_pkg.sv
// Types shared by the overhead capture block
package dbc_pkg;
    // Kind of data link message now on the wire
    typedef enum logic [0:0] {
        DBC_TX_IDLE = 1'b0,
        DBC_TX_CODE = 1'b1
    } dbc_tx_e;

    // Receive line timing and data from the framer
    typedef struct packed {
        logic bit_en;
        logic data;
        logic frame_start;
        logic align;
        logic mf_start;
        logic [3:0] frame_num;
    } dbc_rx_s;

    // Processor port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dbc_cpu_s;
endpackage : dbc_pkg

// ### rtl/dbc_top.sv
// Bit-oriented code transmit/receive and E1 overhead bit capture
`timescale 1ns/1ps
`include "dbc_cfg.svh"

//Contract
// - Send stored code repeatedly while send enabled
// - Send idle flag while send disabled
// - Code field is six bits of sixteen
// - Transmit code bit zero first
// - Store validated received code, read-only
// - First received code bit in bit zero
// - New code sets detected flag, may interrupt
// - Code registers active only in ESF mode
// - Latch align frame byte, Si in bit7
// - Normal signal reads pattern 0011011
// - Non-align byte loaded at align start
// - Non-align Si bit7, signal bit6
// - Non-align bit5 is remote alarm
// - Non-align bits4..0 are Sa4..Sa8
// - Even-frame Si bits, frame14 in bit7
// - Odd-frame Si bits, frame15 in bit7
// - Hold multiframe bits, copy next multiframe
// - Multiframe flag marks multiframe boundary
// - Align flag marks align frame start
// - Alarm bits odd frames, frame15 bit7
// - Alarm bits copied at next multiframe
module dbc_top
    import dbc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_esf_mode,
    input wire logic i_e1_mode,
    input wire dbc_cpu_s i_cpu,
    input wire logic i_code_valid,
    input wire logic [5:0] i_code_value,
    input wire logic i_code_detected_clr,
    input wire logic i_code_detected_ie,
    input wire logic i_align_flag_clr,
    input wire logic i_mf_flag_clr,
    input wire logic i_dl_tick,
    input wire dbc_rx_s i_rx,
    output logic [7:0] o_rdata,
    output logic o_dl_bit,
    output logic o_code_detected_flag,
    output logic o_interrupt_request_out,
    output logic o_rx_align_frame_flag,
    output logic o_rx_multiframe_flag
);

    //***********************************************
    // Register storage
    //***********************************************
    logic send_code_enable;
    logic [5:0] tx_code_field;
    logic [5:0] rx_code_field;
    logic [7:0] rx_align_frame_bits;
    logic [7:0] rx_nonalign_frame_bits;
    logic [7:0] rx_intl_bits_even_frames;
    logic [7:0] rx_intl_bits_odd_frames;
    logic [7:0] rx_remote_alarm_bits;
    logic [7:0] next_rdata;

    // Software writes; capture registers have no write path
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            send_code_enable <= 1'b0;
            tx_code_field <= `DBC_RST_CODE;
        end else if (i_cpu.wr) begin
            if (i_cpu.addr == `DBC_ADDR_TX_CTRL) begin
                send_code_enable <= i_cpu.wdata[`DBC_SEND_BIT];
            end
            if (i_cpu.addr == `DBC_ADDR_TX_CODE) begin
                tx_code_field <= i_cpu.wdata[5:0];
            end
        end
    end

    // Read data mux, unmapped offsets read zero
    always_comb begin
        unique case (i_cpu.addr)
            `DBC_ADDR_TX_CTRL: begin
                next_rdata = `DBC_RST_BYTE;
                next_rdata[`DBC_SEND_BIT] = send_code_enable;
            end
            `DBC_ADDR_RX_CODE: next_rdata = {2'b00, rx_code_field};
            `DBC_ADDR_TX_CODE: next_rdata = {2'b00, tx_code_field};
            `DBC_ADDR_ALIGN: next_rdata = rx_align_frame_bits;
            `DBC_ADDR_NONALIGN: next_rdata = rx_nonalign_frame_bits;
            `DBC_ADDR_SI_EVEN: next_rdata = rx_intl_bits_even_frames;
            `DBC_ADDR_SI_ODD: next_rdata = rx_intl_bits_odd_frames;
            `DBC_ADDR_RAI: next_rdata = rx_remote_alarm_bits;
            default: next_rdata = `DBC_RST_BYTE;
        endcase
    end

    // Read data registered, valid the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= `DBC_RST_BYTE;
        end else if (i_cpu.rd) begin
            o_rdata <= next_rdata;
        end
    end

    //***********************************************
    // Data link transmitter
    //***********************************************
    dbc_tx_e tx_kind;
    logic [15:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_last;
    logic tx_send;

    assign tx_send = send_code_enable && i_esf_mode;
    assign tx_last = (tx_kind == DBC_TX_CODE) ? (tx_cnt == `DBC_CODE_LEN)
                                              : (tx_cnt == `DBC_IDLE_LEN);

    // Messages are never cut short; a new choice waits for the boundary
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_kind <= DBC_TX_IDLE;
            tx_sh <= {8'h00, `DBC_IDLE_FLAG};
            tx_cnt <= 4'h0;
            o_dl_bit <= 1'b0;
        end else if (i_dl_tick) begin
            o_dl_bit <= tx_sh[0];
            if (tx_last) begin
                tx_cnt <= 4'h0;
                if (tx_send) begin
                    tx_kind <= DBC_TX_CODE;
                    // 0, d0..d5, 0, then eight ones
                    tx_sh <= {`DBC_CODE_LEAD, 1'b0, tx_code_field,
                              1'b0};
                end else begin
                    tx_kind <= DBC_TX_IDLE;
                    tx_sh <= {8'h00, `DBC_IDLE_FLAG};
                end
            end else begin
                tx_cnt <= tx_cnt + 4'h1;
                tx_sh <= {1'b0, tx_sh[15:1]};
            end
        end
    end

    //***********************************************
    // Received code capture
    //***********************************************
    logic code_take;

    assign code_take = i_code_valid && i_esf_mode;

    // Filter hands bit zero as first received bit
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_code_field <= `DBC_RST_CODE;
        end else if (code_take) begin
            rx_code_field <= i_code_value;
        end
    end

    // Detected flag: a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_code_detected_flag <= 1'b0;
        end else if (code_take) begin
            o_code_detected_flag <= 1'b1;
        end else if (i_code_detected_clr) begin
            o_code_detected_flag <= 1'b0;
        end
    end

    // Request follows the flag one cycle later
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_interrupt_request_out <= 1'b0;
        end else begin
            o_interrupt_request_out <= o_code_detected_flag &&
                                       i_code_detected_ie;
        end
    end

    //***********************************************
    // E1 frame overhead capture
    //***********************************************
    logic [6:0] cap_sh;
    logic [2:0] cap_cnt;
    logic cap_busy;
    logic cap_align;
    logic [3:0] cap_frame;
    logic cap_done;
    logic [7:0] cap_byte;
    logic [7:0] hold_align;
    logic [7:0] hold_nonalign;
    logic [7:0] hold_even;
    logic [7:0] hold_odd;
    logic [7:0] hold_rai;
    logic align_start;
    logic mf_start;

    assign align_start = i_e1_mode && i_rx.frame_start && i_rx.align;
    assign mf_start = align_start && i_rx.mf_start;
    assign cap_done = cap_busy && i_rx.bit_en && (cap_cnt == `DBC_LAST_BIT);
    // First received bit lands in bit 7
    assign cap_byte = {cap_sh, i_rx.data};

    // Gather the first eight bits of each frame
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cap_sh <= 7'h00;
            cap_cnt <= 3'h0;
            cap_busy <= 1'b0;
            cap_align <= 1'b0;
            cap_frame <= 4'h0;
        end else if (i_e1_mode && i_rx.frame_start) begin
            cap_cnt <= 3'h0;
            cap_busy <= 1'b1;
            cap_align <= i_rx.align;
            cap_frame <= i_rx.frame_num;
        end else if (cap_busy && i_rx.bit_en) begin
            cap_sh <= cap_byte[6:0];
            cap_cnt <= cap_cnt + 3'h1;
            if (cap_cnt == `DBC_LAST_BIT) begin
                cap_busy <= 1'b0;
            end
        end
    end

    // Holding storage filled as each frame's byte completes
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_align <= `DBC_RST_BYTE;
            hold_nonalign <= `DBC_RST_BYTE;
            hold_even <= `DBC_RST_BYTE;
            hold_odd <= `DBC_RST_BYTE;
            hold_rai <= `DBC_RST_BYTE;
        end else if (cap_done) begin
            if (cap_align) begin
                hold_align <= cap_byte;
                hold_even[cap_frame[3:1]] <= cap_byte[7];
            end else begin
                hold_nonalign <= cap_byte;
                hold_odd[cap_frame[3:1]] <= cap_byte[7];
                hold_rai[cap_frame[3:1]] <= cap_byte[`DBC_RAI_POS];
            end
        end
    end

    // Bytes kept whole: Si, pattern/signal, alarm, Sa4..Sa8 in place
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_align_frame_bits <= `DBC_RST_BYTE;
            rx_nonalign_frame_bits <= `DBC_RST_BYTE;
        end else if (align_start) begin
            rx_align_frame_bits <= hold_align;
            rx_nonalign_frame_bits <= hold_nonalign;
        end
    end

    // Multiframe registers change only on the boundary
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_intl_bits_even_frames <= `DBC_RST_BYTE;
            rx_intl_bits_odd_frames <= `DBC_RST_BYTE;
            rx_remote_alarm_bits <= `DBC_RST_BYTE;
        end else if (mf_start) begin
            rx_intl_bits_even_frames <= hold_even;
            rx_intl_bits_odd_frames <= hold_odd;
            rx_remote_alarm_bits <= hold_rai;
        end
    end

    // Frame status flags; set beats clear
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_align_frame_flag <= 1'b0;
            o_rx_multiframe_flag <= 1'b0;
        end else begin
            if (align_start) begin
                o_rx_align_frame_flag <= 1'b1;
            end else if (i_align_flag_clr) begin
                o_rx_align_frame_flag <= 1'b0;
            end
            if (mf_start) begin
                o_rx_multiframe_flag <= 1'b1;
            end else if (i_mf_flag_clr) begin
                o_rx_multiframe_flag <= 1'b0;
            end
        end
    end

    //***********************************************
    // Assertions
    //***********************************************
    default clocking dbc_cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_boundary_send;
        i_dl_tick && tx_last && tx_send;
    endsequence

    sequence s_boundary_idle;
        i_dl_tick && tx_last && !tx_send;
    endsequence

    code_load_a: assert property (s_boundary_send |=>
        tx_kind == DBC_TX_CODE &&
        tx_sh == {`DBC_CODE_LEAD, 1'b0, $past(tx_code_field), 1'b0})
        else $error("code message not loaded");
    idle_load_a: assert property (s_boundary_idle |=>
        tx_kind == DBC_TX_IDLE && tx_sh[7:0] == `DBC_IDLE_FLAG)
        else $error("idle flag not loaded");

    // Code held for the whole message, so a write mid-message cannot
    // blur the bit order check
    logic [5:0] code_on_wire;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            code_on_wire <= `DBC_RST_CODE;
        end else if (i_dl_tick && tx_last && tx_send) begin
            code_on_wire <= tx_code_field;
        end
    end

    code_first_a: assert property (
        i_dl_tick && tx_kind == DBC_TX_CODE && tx_cnt == `DBC_FIRST_DATA
        |=> o_dl_bit == code_on_wire[0])
        else $error("code bit zero not first");
    code_store_a: assert property (code_take |=>
        rx_code_field == $past(i_code_value) && o_code_detected_flag)
        else $error("received code not stored");
    code_mode_a: assert property (i_code_valid && !i_esf_mode |=>
        $stable(rx_code_field))
        else $error("code stored outside ESF mode");
    irq_follow_a: assert property (
        o_code_detected_flag && i_code_detected_ie |=> o_interrupt_request_out)
        else $error("interrupt request missing");
    align_latch_a: assert property (align_start |=>
        o_rx_align_frame_flag && rx_align_frame_bits == $past(hold_align))
        else $error("align frame not latched");
    mf_copy_a: assert property (mf_start |=> o_rx_multiframe_flag &&
        rx_intl_bits_odd_frames == $past(hold_odd) &&
        rx_remote_alarm_bits == $past(hold_rai))
        else $error("multiframe bits not copied");
    ro_write_a: assert property (i_cpu.wr && !align_start && !mf_start &&
        !code_take |=> $stable(rx_align_frame_bits) &&
        $stable(rx_intl_bits_even_frames) && $stable(rx_code_field))
        else $error("read-only register changed by write");

endmodule : dbc_top

// ### verif/dbc_line_model.sv
// Remote line equipment model sending E1 frames into the receiver
`timescale 1ns/1ps
module dbc_line_model
    import dbc_pkg::*;
(
    input wire logic i_core_clk,
    output dbc_rx_s o_rx
);
    // Line starts quiet until the first frame is sent
    initial begin
        o_rx = '0;
    end

    // One frame: a start strobe, then eight bit strobes, MSB first
    // Qualifiers flip off their strobe so stale values never help
    task automatic send_frame(input logic align, input logic mf,
            input logic [3:0] num, input logic [7:0] val);
        int i;
        @(negedge i_core_clk);
        o_rx.frame_start = 1'b1;
        o_rx.align = align;
        o_rx.mf_start = mf;
        o_rx.frame_num = num;
        o_rx.data = ~o_rx.data;
        @(negedge i_core_clk);
        o_rx.frame_start = 1'b0;
        o_rx.align = ~align;
        o_rx.mf_start = ~mf;
        for (i = 7; i >= 0; i--) begin
            o_rx.data = val[i];
            o_rx.bit_en = 1'b1;
            @(negedge i_core_clk);
            o_rx.bit_en = 1'b0;
            o_rx.data = ~val[i];
            @(negedge i_core_clk);
        end
    endtask : send_frame
endmodule : dbc_line_model

// ### verif/dbc_top_tb.sv
// Self-checking bench for the overhead capture block
`timescale 1ns/1ps
module dbc_top_tb
    import dbc_pkg::*;
;
    logic clk, resetn, esf, e1, cval, cclr, cie, aclr, mclr, tick;
    logic [5:0] cval_v, code;
    logic [7:0] rdata, se, so, ra;
    logic [7:0] fb[16];
    logic dl_bit, det, irq, aflag, mflag, rd_d, tick_d;
    dbc_cpu_s cpu;
    dbc_rx_s rx;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] rd_q[$];
    logic dl_q[$];

    dbc_top i_dut (.i_core_clk(clk), .i_resetn(resetn), .i_esf_mode(esf),
        .i_e1_mode(e1), .i_cpu(cpu), .i_code_valid(cval),
        .i_code_value(cval_v), .i_code_detected_clr(cclr),
        .i_code_detected_ie(cie), .i_align_flag_clr(aclr),
        .i_mf_flag_clr(mclr), .i_dl_tick(tick), .i_rx(rx), .o_rdata(rdata),
        .o_dl_bit(dl_bit), .o_code_detected_flag(det),
        .o_interrupt_request_out(irq), .o_rx_align_frame_flag(aflag),
        .o_rx_multiframe_flag(mflag));
    dbc_line_model i_line (.i_core_clk(clk), .o_rx(rx));

    // 20 MHz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // Bus cycle; released lines show inverted junk, never the old value
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu = {w, ~w, a, d};
        @(negedge clk);
        cpu = {2'b00, ~a, ~d};
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask : ticks

    // Expected data link message, first bit on the wire first
    task automatic push_msg(input logic send);
        logic [15:0] m;
        m = send ? {8'hff, 1'b0, code, 1'b0} : 16'h007e;
        for (int i = 0; i < (send ? 16 : 8); i++) begin
            dl_q.push_back(m[i]);
        end
    endtask : push_msg

    task automatic code_in(input logic [5:0] v);
        @(negedge clk);
        cval = 1'b1;
        cval_v = v;
        @(negedge clk);
        cval = 1'b0;
        cval_v = ~v;
    endtask : code_in

    // Result watcher plus the hang guard; a stuck run counts as a mismatch
    always @(posedge clk) begin
        rd_d <= cpu.rd;
        tick_d <= tick;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    // Compare each read and each data link bit against the oldest note
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            check("rdata", rdata, rd_q.pop_front());
        end
        if (tick_d === 1'b1) begin
            check("dl_bit", {7'h0, dl_bit}, {7'h0, dl_q.pop_front()});
        end
    end

    initial begin
        {resetn, e1, cval, cclr, cie, aclr, mclr, tick} = '0;
        esf = 1'b1;
        cval_v = '0;
        cpu = '0;
        void'($urandom(32'h4869));
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        // Reset values of the whole register table
        foreach (fb[i]) begin
            fb[i] = 8'h00;
        end
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        rd(8'h43, 8'h00);
        for (int a = 8'h50; a <= 8'h54; a++) begin
            rd(8'(a), 8'h00);
        end
        $display("done: reset values");
        // Data link: idle, then code twice, disable lands mid code
        code = 6'($urandom);
        bus(1'b1, 8'h43, {2'b11, code});
        rd(8'h43, {2'b00, code});
        bus(1'b1, 8'h41, 8'h40);
        rd(8'h41, 8'h40);
        push_msg(1'b0);
        push_msg(1'b1);
        push_msg(1'b1);
        ticks(30);
        bus(1'b1, 8'h41, 8'h00);
        push_msg(1'b0);
        push_msg(1'b0);
        ticks(26);
        $display("done: data link");
        // Code capture: enabled, masked, then outside ESF mode
        cie = 1'b1;
        code = 6'($urandom);
        code_in(code);
        check("flag", {7'h0, det}, 8'h01);
        @(negedge clk);
        check("irq", {7'h0, irq}, 8'h01);
        rd(8'h42, {2'b00, code});
        cclr = 1'b1;
        @(negedge clk);
        cclr = 1'b0;
        check("flag", {7'h0, det}, 8'h00);
        cie = 1'b0;
        code = ~code;
        // Clear held across the new code: the set must win
        cclr = 1'b1;
        code_in(code);
        cclr = 1'b0;
        check("flag", {7'h0, det}, 8'h01);
        @(negedge clk);
        check("irq", {7'h0, irq}, 8'h00);
        cclr = 1'b1;
        @(negedge clk);
        cclr = 1'b0;
        esf = 1'b0;
        code_in(~code);
        check("flag", {7'h0, det}, 8'h00);
        rd(8'h42, {2'b00, code});
        $display("done: code capture");
        // E1 multiframe of random overhead bytes
        e1 = 1'b1;
        for (int f = 0; f < 16; f++) begin
            fb[f] = f[0] ? (8'($urandom) | 8'h40) : {1'($urandom), 7'h1b};
            if (f[0]) begin
                so[f / 2] = fb[f][7];
                ra[f / 2] = fb[f][5];
            end else begin
                se[f / 2] = fb[f][7];
            end
            i_line.send_frame(~f[0], f == 0, 4'(f), fb[f]);
        end
        rd(8'h50, fb[12]);
        rd(8'h51, fb[13]);
        rd(8'h52, 8'h00);
        {aclr, mclr} = 2'b11;
        @(negedge clk);
        {aclr, mclr} = 2'b00;
        check("align flag", {7'h0, aflag}, 8'h00);
        i_line.send_frame(1'b1, 1'b1, 4'h0, 8'h9b);
        check("align flag", {7'h0, aflag}, 8'h01);
        check("mf flag", {7'h0, mflag}, 8'h01);
        rd(8'h50, fb[14]);
        rd(8'h51, fb[15]);
        rd(8'h52, se);
        rd(8'h53, so);
        rd(8'h54, ra);
        bus(1'b1, 8'h50, ~fb[14]);
        bus(1'b1, 8'h42, 8'hff);
        rd(8'h50, fb[14]);
        rd(8'h42, {2'b00, code});
        rd(8'h60, 8'h00);
        $display("done: E1 capture");
        repeat (2) @(negedge clk);
        check("left", 8'(rd_q.size() + dl_q.size()), 8'h00);
        stop_test();
    end
endmodule : dbc_top_tb
